// ### gate_ctrl_consts.vh
`ifndef GATE_CTRL_CONSTS_VH
`define GATE_CTRL_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define GC_CTRL_OFS       8'h00
`define GC_STAT_OFS       8'h04
`define GC_IRQ_STAT_OFS   8'h08
`define GC_IRQ_MASK_OFS   8'h0c
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define GC_CTRL_GE_BIT    0
`define GC_CTRL_TM_BIT    1
`define GC_CTRL_SPM_BIT   2
`define GC_CTRL_ARM_BIT   3
`define GC_CTRL_POL_BIT   4
`define GC_CTRL_SRC_BIT   5
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define GC_STAT_VAL_BIT   0
`define GC_STAT_ACT_BIT   1
`define GC_STAT_TFF_BIT   2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GC_CTRL_RST       6'h00
`define GC_MASK_RST       1'h0
// ----------------------------------------
// Bus responses
// ----------------------------------------
`define GC_RESP_OKAY      2'h0
`define GC_RESP_SLVERR    2'h2
`endif

// ### edge_sync.v
`timescale 1ns/1ps
// ----------------------------------------
// Two-stage synchroniser with edge pulses
// ----------------------------------------
module edge_sync
(
   input  wire sys_clk,
   input  wire reset_n,
   input  wire async_in,
   output reg  level_r,
   output reg  rise_r,
   output reg  fall_r
);
   reg meta_r;
   reg sync_r;

   // Only sync_r reads meta_r
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r  <= 1'b0;
         sync_r  <= 1'b0;
         level_r <= 1'b0;
         rise_r  <= 1'b0;
         fall_r  <= 1'b0;
      end
      else
      begin
         meta_r  <= async_in;
         sync_r  <= meta_r;
         level_r <= sync_r;
         rise_r  <= sync_r & ~level_r;
         fall_r  <= ~sync_r & level_r;
      end
   end
endmodule // edge_sync

// ### gate_control.v
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "gate_ctrl_consts.vh"
module gate_control
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        gate_input_pin,
   input  wire        overflow_tick,
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output reg         awready,
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output reg         wready,
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output reg         arready,
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   output reg         count_enable_r,
   output reg         irq_r
);
   // ----------------------------------------
   // Control and status state
   // ----------------------------------------
   reg        gate_enable_r;
   reg        gate_toggle_enable_r;
   reg        gate_single_pulse_enable_r;
   reg        single_pulse_arm_r;
   reg        gate_polarity_r;
   reg        gate_source_r;
   reg        toggle_ff_r;
   reg        pulse_open_r;
   reg        gate_level_value_r;
   reg        gate_event_flag_r;
   reg        gate_event_int_enable_r;
   reg        ovf_pulse_r;
   reg        aw_hold_r;
   reg        w_hold_r;
   reg [7:0]  aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0]  w_strb_r;

   wire       pin_level;
   wire       pin_rise;
   wire       pin_fall;
   wire       raw_gate;
   wire       pol_gate;
   wire       proc_gate;
   wire       gate_rise;
   wire       gate_fall;
   wire       gate_active;
   wire       wr_fire;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire       arm_write;
   wire       ctrl_hit;

   // ----------------------------------------
   // Gate sources
   // ----------------------------------------
   edge_sync u_pin_sync
   (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .async_in (gate_input_pin),
      .level_r  (pin_level),
      .rise_r   (pin_rise),
      .fall_r   (pin_fall)
   );

   // Tick is one cycle on the wrap to zero; registered once, so the pulse stays one cycle
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         ovf_pulse_r <= 1'b0;
      else
         ovf_pulse_r <= overflow_tick;
   end

   assign raw_gate  = gate_source_r ? ovf_pulse_r : pin_level;
   assign pol_gate  = raw_gate ^ gate_polarity_r;
   // Edges of the polarised gate; pin edges are registered, overflow edges use the raw overflow_tick input
   // Overflow edges come from the tick; polarity swaps them like the pin edges
   wire ovf_rise = overflow_tick & ~ovf_pulse_r;
   wire ovf_fall = ~overflow_tick & ovf_pulse_r;
   assign gate_rise = gate_source_r ? (gate_polarity_r ? ovf_fall : ovf_rise)
                                    : (gate_polarity_r ? pin_fall : pin_rise);
   assign gate_fall = gate_source_r ? (gate_polarity_r ? ovf_rise : ovf_fall)
                                    : (gate_polarity_r ? pin_rise : pin_fall);
   assign proc_gate = gate_toggle_enable_r ? toggle_ff_r : pol_gate;

   // ----------------------------------------
   // Toggle and single-pulse logic
   // ----------------------------------------
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         toggle_ff_r <= 1'b0;
      else if (!gate_toggle_enable_r)
         toggle_ff_r <= 1'b0;
      else if (gate_rise)
         toggle_ff_r <= ~toggle_ff_r;
   end

   // Window opens on the rising edge of the processed gate after arming
   wire proc_rise = gate_toggle_enable_r ? (gate_rise & ~toggle_ff_r) : gate_rise;
   wire proc_fall = gate_toggle_enable_r ? (gate_rise & toggle_ff_r) : gate_fall;

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
         pulse_open_r <= 1'b0;
      else if (!gate_single_pulse_enable_r || !single_pulse_arm_r)
         pulse_open_r <= 1'b0;
      else if (proc_rise)
         pulse_open_r <= 1'b1;
   end

   assign gate_active = gate_single_pulse_enable_r
                        ? (pulse_open_r & single_pulse_arm_r & proc_gate)
                        : proc_gate;

   // Level value reflects the windowed gate in single-pulse mode, else the processed gate, regardless of gate enable
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_level_value_r <= 1'b0;
         count_enable_r     <= 1'b0;
      end
      else
      begin
         gate_level_value_r <= gate_single_pulse_enable_r ? gate_active : proc_gate;
         count_enable_r     <= gate_enable_r ? gate_active : 1'b1;
      end
   end

   wire level_fall = gate_level_value_r &
                     ~(gate_single_pulse_enable_r ? gate_active : proc_gate);

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   assign wr_fire = (aw_hold_r | (awvalid & awready)) & (w_hold_r | (wvalid & wready)) & ~bvalid;
   assign wr_addr = aw_hold_r ? aw_addr_r : awaddr;
   assign wr_data = w_hold_r ? w_data_r : wdata;
   assign wr_strb = w_hold_r ? w_strb_r : wstrb;
   assign ctrl_hit = wr_fire & (wr_addr == `GC_CTRL_OFS) & wr_strb[0];
   assign arm_write = ctrl_hit & wr_data[`GC_CTRL_ARM_BIT];

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `GC_RESP_OKAY;
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h00000000;
         w_strb_r  <= 4'h0;
      end
      else
      begin
         awready <= ~aw_hold_r & ~(awvalid & awready) & ~bvalid;
         wready  <= ~w_hold_r & ~(wvalid & wready) & ~bvalid;
         if (awvalid & awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= awaddr;
         end
         if (wvalid & wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (wr_fire)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid    <= 1'b1;
            awready   <= 1'b0;
            wready    <= 1'b0;
            if (wr_addr == `GC_CTRL_OFS || wr_addr == `GC_STAT_OFS ||
                wr_addr == `GC_IRQ_STAT_OFS || wr_addr == `GC_IRQ_MASK_OFS)
               bresp <= `GC_RESP_OKAY;
            else
               bresp <= `GC_RESP_SLVERR;
         end
         else if (bvalid & bready)
            bvalid <= 1'b0;
      end
   end

   // Control writes; a software arm write beats a simultaneous hardware clear
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_enable_r              <= 1'b0;
         gate_toggle_enable_r       <= 1'b0;
         gate_single_pulse_enable_r <= 1'b0;
         single_pulse_arm_r         <= 1'b0;
         gate_polarity_r            <= 1'b0;
         gate_source_r              <= 1'b0;
         gate_event_int_enable_r    <= `GC_MASK_RST;
      end
      else
      begin
         if (ctrl_hit)
         begin
            gate_enable_r              <= wr_data[`GC_CTRL_GE_BIT];
            gate_toggle_enable_r       <= wr_data[`GC_CTRL_TM_BIT];
            gate_single_pulse_enable_r <= wr_data[`GC_CTRL_SPM_BIT];
            gate_polarity_r            <= wr_data[`GC_CTRL_POL_BIT];
            gate_source_r              <= wr_data[`GC_CTRL_SRC_BIT];
            single_pulse_arm_r         <= wr_data[`GC_CTRL_ARM_BIT];
         end
         // Trailing edge of captured pulse ends the measurement
         if (gate_single_pulse_enable_r & pulse_open_r & proc_fall & ~arm_write)
            single_pulse_arm_r <= 1'b0;
         if (wr_fire & (wr_addr == `GC_IRQ_MASK_OFS) & wr_strb[0])
            gate_event_int_enable_r <= wr_data[0];
      end
   end

   // Flag set wins over a write-one clear in the same cycle
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         gate_event_flag_r <= 1'b0;
         irq_r             <= 1'b0;
      end
      else
      begin
         if (level_fall)
            gate_event_flag_r <= 1'b1;
         else if (wr_fire & (wr_addr == `GC_IRQ_STAT_OFS) & wr_strb[0] & wr_data[0])
            gate_event_flag_r <= 1'b0;
         irq_r <= gate_event_flag_r & gate_event_int_enable_r;
      end
   end

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h00000000;
         rresp   <= `GC_RESP_OKAY;
      end
      else
      begin
         arready <= ~rvalid & ~(arvalid & arready);
         if (arvalid & arready)
         begin
            rvalid  <= 1'b1;
            arready <= 1'b0;
            rresp   <= `GC_RESP_OKAY;
            rdata   <= 32'h00000000;
            case (araddr)
               `GC_CTRL_OFS:
                  rdata[5:0] <= {gate_source_r, gate_polarity_r, single_pulse_arm_r,
                                 gate_single_pulse_enable_r, gate_toggle_enable_r,
                                 gate_enable_r};
               `GC_STAT_OFS:
                  rdata[2:0] <= {toggle_ff_r, count_enable_r, gate_level_value_r};
               `GC_IRQ_STAT_OFS:
                  rdata[0] <= gate_event_flag_r;
               `GC_IRQ_MASK_OFS:
                  rdata[0] <= gate_event_int_enable_r;
               default:
                  rresp <= `GC_RESP_SLVERR;
            endcase
         end
         else if (rvalid & rready)
            rvalid <= 1'b0;
      end
   end
endmodule // gate_control

// ### gate_source_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Outside gate pin and overflow timer
// ----------------------------------------
module gate_source_model
(
   input  wire sys_clk,
   input  wire reset_n,
   input  wire pin_req,
   input  wire run,
   output reg  gate_input_pin,
   output reg  overflow_tick
);
   reg [7:0] count_r;
   initial gate_input_pin = 1'b0;
   // Pin moves off the clock edge, like a real outside signal
   always @(pin_req)
      gate_input_pin <= #7 pin_req;
   always @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         count_r <= 8'h00;
         overflow_tick <= 1'b0;
      end
      else
      begin
         if (run)
            count_r <= count_r + 8'h01;
         overflow_tick <= run && count_r == 8'hff;
      end
endmodule // gate_source_model

// ### gate_control_asserts.sv
`timescale 1ns/1ps
`include "gate_ctrl_consts.vh"
module gate_control_asserts
(
   input wire        sys_clk,
   input wire        reset_n,
   input wire        gate_input_pin,
   input wire [7:0]  awaddr,
   input wire        awvalid,
   input wire        awready,
   input wire [31:0] wdata,
   input wire        wvalid,
   input wire        wready,
   input wire        bvalid,
   input wire [7:0]  araddr,
   input wire        arvalid,
   input wire        arready,
   input wire [1:0]  rresp,
   input wire        count_enable_r,
   input wire        irq_r
);
   reg  [5:0] ctrl_r;
   reg        mask_r;
   wire       wr_go = awvalid && awready && wvalid && wready;
   wire       plain = ctrl_r[2:1] == 2'h0 && ctrl_r[5:4] == 2'h0;
   wire       idle  = ctrl_r[0] && ctrl_r[2] && !ctrl_r[3];
   // Software view only; a hardware arm clear is not seen here
   always @(posedge sys_clk or negedge reset_n)
      if (!reset_n)
      begin
         ctrl_r <= 6'h00;
         mask_r <= 1'b0;
      end
      else if (wr_go)
      begin
         if (awaddr == `GC_CTRL_OFS)
            ctrl_r <= wdata[5:0];
         if (awaddr == `GC_IRQ_MASK_OFS)
            mask_r <= wdata[0];
      end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_write_answer: assert property (wr_go |=> bvalid)
      else $error("write response missing");
   a_busy_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   a_read_unmapped: assert property (arvalid && arready && araddr > 8'h0c |=> rresp == 2'h2)
      else $error("unmapped read not refused");
   a_ungated_runs: assert property ($past(reset_n) && !$past(ctrl_r[0]) |-> count_enable_r)
      else $error("counter stopped without gate");
   a_single_idle: assert property ($past(idle, 2) && $past(idle) |-> !count_enable_r)
      else $error("counting while not armed");
   a_irq_masked: assert property (!$past(mask_r) |-> !irq_r)
      else $error("interrupt while masked");
   a_fall_flags: assert property ($fell(gate_input_pin) && plain && mask_r |-> ##[3:10] irq_r)
      else $error("gate fall raised no interrupt");
   a_rise_counts: assert property ($rose(gate_input_pin) && ctrl_r == 6'h01 |-> ##[3:10] count_enable_r)
      else $error("gate rise did not enable counting");
endmodule // gate_control_asserts
bind gate_control gate_control_asserts u_gate_control_asserts
(
   .sys_clk(sys_clk), .reset_n(reset_n), .gate_input_pin(gate_input_pin),
   .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rresp(rresp), .count_enable_r(count_enable_r), .irq_r(irq_r)
);

// ### testbench.sv
`timescale 1ns/1ps
`include "gate_ctrl_consts.vh"
module testbench;
   reg         sys_clk, reset_n, pin_req, run, awvalid, wvalid, bready, arvalid, rready;
   reg  [7:0]  awaddr, araddr;
   reg  [31:0] wdata, rd_d;
   reg  [3:0]  wstrb;
   reg  [1:0]  rsp;
   wire        gate_input_pin, overflow_tick, awready, wready, bvalid, arready, rvalid;
   wire        count_enable_r, irq_r;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [31:0] ce_w = {31'h0, count_enable_r};
   wire [31:0] irq_w = {31'h0, irq_r};
   integer     miscompares, checks;
   always #12.5 sys_clk = ~sys_clk;
   gate_control u_gate_control
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .gate_input_pin(gate_input_pin),
      .overflow_tick(overflow_tick), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .count_enable_r(count_enable_r), .irq_r(irq_r)
   );
   gate_source_model u_gate_source_model
   (
      .sys_clk(sys_clk), .reset_n(reset_n), .pin_req(pin_req), .run(run),
      .gate_input_pin(gate_input_pin), .overflow_tick(overflow_tick)
   );
   task end_sim;
   begin
      if (miscompares == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task chk(input string what, input [31:0] e, input [31:0] g);
   begin
      checks = checks + 1;
      if (g !== e)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   end
   endtask
   // ----------------------------------------
   // Bus cycles; ready for answers stays high
   // ----------------------------------------
   task wr(input [7:0] a, input [31:0] d);
      reg ta, tw;
   begin
      ta = 1'b0;
      tw = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge sys_clk);
         if (awvalid && awready)
         begin
            awvalid <= 1'b0;
            ta = 1'b1;
         end
         if (wvalid && wready)
         begin
            wvalid <= 1'b0;
            tw = 1'b1;
         end
      end
      do @(posedge sys_clk); while (!bvalid);
      rsp = bresp;
   end
   endtask
   task rd(input [7:0] a);
   begin
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (!rvalid);
      rd_d = rdata;
      rsp = rresp;
   end
   endtask
   // Pin path is a synchroniser plus edge stage; ten cycles covers it
   task pin(input v);
   begin
      pin_req <= v;
      repeat (10) @(posedge sys_clk);
   end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
   begin
      rd(`GC_CTRL_OFS);
      chk("ctrl reset", 32'h0, rd_d);
      rd(`GC_IRQ_MASK_OFS);
      chk("mask reset", 32'h0, rd_d);
      rd(8'h10);
      chk("rd unmapped", {30'h0, `GC_RESP_SLVERR}, {30'h0, rsp});
      chk("rd unmapped data", 32'h0, rd_d);
      wr(8'h10, 32'h1);
      chk("wr unmapped", {30'h0, `GC_RESP_SLVERR}, {30'h0, rsp});
   end
   endtask
   task t_level;
   begin
      pin(1'b1);
      rd(`GC_STAT_OFS);
      chk("level", 32'h1, rd_d & 32'h1);
      chk("count en", 32'h1, ce_w);
      pin(1'b0);
      rd(`GC_IRQ_STAT_OFS);
      chk("flag", 32'h1, rd_d);
      chk("irq", 32'h0, irq_w);
      wr(`GC_IRQ_MASK_OFS, 32'h1);
      pin(1'b0);
      chk("irq", 32'h1, irq_w);
      wr(`GC_IRQ_STAT_OFS, 32'h1);
      pin(1'b0);
      chk("irq", 32'h0, irq_w);
   end
   endtask
   task t_pattern(input [5:0] ctl, input [3:0] exp);
      integer i;
   begin
      wr(`GC_CTRL_OFS, {26'h0, ctl});
      for (i = 0; i < 4; i = i + 1)
      begin
         pin(i % 2 == 0);
         chk("count en", {31'h0, exp[3 - i]}, ce_w);
      end
   end
   endtask
   task t_toggle_clear;
   begin
      wr(`GC_CTRL_OFS, 32'h3);
      pin(1'b1);
      rd(`GC_STAT_OFS);
      chk("toggle ff", 32'h4, rd_d & 32'h4);
      wr(`GC_CTRL_OFS, 32'h1);
      pin(1'b1);
      rd(`GC_STAT_OFS);
      chk("toggle ff", 32'h0, rd_d & 32'h4);
      chk("count en", 32'h1, ce_w);
      pin(1'b0);
   end
   endtask
   // Inverted polarity: pin high means gate idle, so a pin rise is a gate fall
   task t_polarity;
   begin
      wr(`GC_CTRL_OFS, 32'h11);
      pin(1'b0);
      chk("count en", 32'h1, ce_w);
      wr(`GC_IRQ_STAT_OFS, 32'h1);
      pin(1'b1);
      chk("count en", 32'h0, ce_w);
      rd(`GC_IRQ_STAT_OFS);
      chk("flag", 32'h1, rd_d);
      wr(`GC_CTRL_OFS, 32'h1);
      pin(1'b0);
   end
   endtask
   task t_overflow;
   begin
      wr(`GC_IRQ_STAT_OFS, 32'h1);
      wr(`GC_CTRL_OFS, 32'h21);
      pin(1'b0);
      chk("irq", 32'h0, irq_w);
      run <= 1'b1;
      repeat (300) @(posedge sys_clk);
      run <= 1'b0;
      chk("irq", 32'h1, irq_w);
   end
   endtask
   initial
   begin
      {sys_clk, reset_n, pin_req, run, awvalid, wvalid, arvalid} = 7'h00;
      {awaddr, araddr, wdata} = 48'h0;
      {bready, rready, wstrb} = 6'h31;
      miscompares = 0;
      checks = 0;
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_regs;
      t_level;
      t_pattern(6'h01, 4'b1010);
      t_pattern(6'h03, 4'b1100);
      wr(`GC_CTRL_OFS, 32'h5);
      t_pattern(6'h0d, 4'b1000);
      rd(`GC_CTRL_OFS);
      chk("arm", 32'h5, rd_d);
      wr(`GC_CTRL_OFS, 32'h7);
      t_pattern(6'h0f, 4'b1100);
      rd(`GC_CTRL_OFS);
      chk("arm", 32'h7, rd_d);
      wr(`GC_CTRL_OFS, 32'h1);
      t_toggle_clear;
      t_polarity;
      t_overflow;
      end_sim;
   end
   // Whole run is near 700 cycles
   initial
   begin
      repeat (6000) @(posedge sys_clk);
      miscompares = miscompares + 1;
      end_sim;
   end
endmodule // testbench
